// file: pkg/opdc_defs.vh
/*
 output and deep-sleep control register bank: offsets, field positions,
 reset values and mode codes. assumes inclusion by bare name.
*/
`ifndef OPDC_DEFS_VH
`define OPDC_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OPDC_ADDR_W            13
`define OPDC_OFF_OUT_CTRL      13'h1014
`define OPDC_OFF_SLEEP_CTRL    13'h107C

// ----------------------------------------
// output control fields
// ----------------------------------------
`define OPDC_OUT_WAIT_EN_BIT   0
`define OPDC_OUT_PULLUP_OFF    1
`define OPDC_OUT_TURBO_BIT     2
`define OPDC_OUT_RESET         3'h1

// ----------------------------------------
// deep-sleep control fields and codes
// ----------------------------------------
`define OPDC_SLP_PERMIT_BIT    7
`define OPDC_SLP_RESET         4'h0
`define OPDC_MODE_UNUSED       4'h0
`define OPDC_MODE_EXIT_RISE    4'h1
`define OPDC_MODE_EXIT_FALL    4'h2
`define OPDC_MODE_LEVEL_HIGH   4'h4
`define OPDC_MODE_LEVEL_LOW    4'h8

// ----------------------------------------
// timing
// ----------------------------------------
`define OPDC_SLOW_OE_NS        40
`define OPDC_CLK_NS            20
// settling wait in whole clocks: 40 ns at a 20 ns clock
`define OPDC_SLOW_OE_CYC       4'h2

`endif

// file: hw/opdc_ctrl.v
/*
 output behaviour and deep-sleep pin control registers with the logic they steer.
 assumes a single-cycle register port and inputs synchronous to sys_clk.
*/
// Implementation choice: the strobed register port.
// Contract
// [RL1] output control register resets only on hardware reset, not soft reset mode
// [RL2] writes to output control register accepted regardless of cascade position
// [RL3] bit0 (reset 1) enables boot-wait output during soft-reset download
// [RL4] hardware reset sets bit0; wait output held until boot download finishes
// [RL5] bit1 high disables upper pull-ups; low enables them when width strap is 0
// [RL6] bit2 high enables output buffers at once; low waits a settling delay
// [RL7] output bits 7..3 and sleep bits 6..4 read as zero
// [RL8] mode 0000 ignores pin; 0100 sleeps while pin high; 1000 while low
// [RL9] mode 0001 exits sleep on rising edge; 0010 on falling edge
// [RL10] sleep bit7 reads 1 whenever deep sleep is currently possible
// [RL11] width strap taken directly from its configuration pin level
// [RL12] unlisted mode codes treat the pin as unused
`default_nettype none
`include "opdc_defs.vh"

module opdc_ctrl
(
    // clock and reset
    input  wire                     sys_clk,
    input  wire                     resetn,
    // register port
    input  wire [`OPDC_ADDR_W-1:0]  reg_addr,
    input  wire [7:0]               reg_wdata,
    input  wire                     reg_wr,
    input  wire                     reg_rd,
    output reg  [7:0]               reg_rdata,
    // device state
    input  wire                     soft_reset_mode,
    input  wire                     download_busy,
    input  wire                     soft_download,
    input  wire                     sleep_capable,
    input  wire [1:0]               cascade_position_in,
    // pins
    input  wire                     width_strap_in,
    input  wire                     deep_sleep_pin,
    input  wire                     oe_n_in,
    input  wire                     ce_n_in,
    output reg                      boot_wait_n_out,
    output reg                      boot_wait_oe,
    output reg                      upper_data_pullup_en,
    output reg                      data_out_en,
    output reg                      deep_sleep_active
);

// ----------------------------------------
// one-hot state codes
// ----------------------------------------
localparam [2:0] BOOT_HW    = 3'h1;
localparam [2:0] BOOT_IDLE  = 3'h2;
localparam [2:0] BOOT_SOFT  = 3'h4;
localparam [1:0] SLP_AWAKE  = 2'h1;
localparam [1:0] SLP_ASLEEP = 2'h2;

// ----------------------------------------
// decoding functions
// ----------------------------------------
// register offset match, shared by writes and reads
function addr_hit;
    input [`OPDC_ADDR_W-1:0] addr;
    input [`OPDC_ADDR_W-1:0] offset;
    begin
        addr_hit = (addr == offset);
    end
endfunction

// mode codes that give the pin a role
function mode_listed;
    input [3:0] mode;
    begin
        case (mode)
            `OPDC_MODE_EXIT_RISE:  mode_listed = 1'b1;
            `OPDC_MODE_EXIT_FALL:  mode_listed = 1'b1;
            `OPDC_MODE_LEVEL_HIGH: mode_listed = 1'b1;
            `OPDC_MODE_LEVEL_LOW:  mode_listed = 1'b1;
            default:               mode_listed = 1'b0; // RL12
        endcase
    end
endfunction

// level modes: the pin level that asks for sleep
function level_wants_sleep;
    input [3:0] mode;
    input       pin;
    begin
        case (mode)
            `OPDC_MODE_LEVEL_HIGH: level_wants_sleep = pin; // RL8
            `OPDC_MODE_LEVEL_LOW:  level_wants_sleep = ~pin; // RL8
            default:               level_wants_sleep = 1'b0;
        endcase
    end
endfunction

// edge modes: the pin edge that ends sleep
function edge_ends_sleep;
    input [3:0] mode;
    input       pin;
    input       pin_d;
    begin
        case (mode)
            `OPDC_MODE_EXIT_RISE: edge_ends_sleep = pin & ~pin_d; // RL9
            `OPDC_MODE_EXIT_FALL: edge_ends_sleep = ~pin & pin_d; // RL9
            default:              edge_ends_sleep = 1'b0;
        endcase
    end
endfunction

// level modes follow the pin both ways
function is_level_mode;
    input [3:0] mode;
    begin
        is_level_mode = (mode == `OPDC_MODE_LEVEL_HIGH) | (mode == `OPDC_MODE_LEVEL_LOW);
    end
endfunction

// ----------------------------------------
// registers and decode
// ----------------------------------------
reg  [2:0]  out_ctrl_r;
reg  [3:0]  sleep_mode_r;
reg  [2:0]  boot_state_r;
reg  [2:0]  boot_state_nxt;
reg  [1:0]  sleep_state_r;
reg  [1:0]  sleep_state_nxt;
reg         pin_d_r;
reg  [3:0]  oe_cnt_r;
reg  [3:0]  oe_cnt_nxt;
wire        wr_out       = reg_wr & addr_hit(reg_addr, `OPDC_OFF_OUT_CTRL);
wire        wr_sleep     = reg_wr & addr_hit(reg_addr, `OPDC_OFF_SLEEP_CTRL);
wire        rd_out       = reg_rd & addr_hit(reg_addr, `OPDC_OFF_OUT_CTRL);
wire        rd_sleep     = reg_rd & addr_hit(reg_addr, `OPDC_OFF_SLEEP_CTRL);
wire        oe_req       = ~oe_n_in & ~ce_n_in;
wire        soft_wait    = download_busy & soft_download & out_ctrl_r[`OPDC_OUT_WAIT_EN_BIT];
wire        slow_oe_done = (oe_cnt_r >= `OPDC_SLOW_OE_CYC);
wire [7:0]  out_view     = {5'h00, out_ctrl_r};
wire [7:0]  sleep_view   = {sleep_capable, 3'h0, sleep_mode_r};
wire [7:0]  rdata_nxt;

// ----------------------------------------
// register writes
// ----------------------------------------
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        out_ctrl_r   <= `OPDC_OUT_RESET; // RL1 RL4
        sleep_mode_r <= `OPDC_SLP_RESET;
    end
    else
    begin
        // soft reset mode and cascade position never gate these writes
        if (wr_out)
        begin
            out_ctrl_r <= reg_wdata[2:0]; // RL1 RL2
        end
        if (wr_sleep)
        begin
            sleep_mode_r <= reg_wdata[3:0];
        end
    end
end

// ----------------------------------------
// read data, one cycle later
// ----------------------------------------
genvar gi;
generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_rd_bit
        assign rdata_nxt[gi] = (rd_out & out_view[gi]) | (rd_sleep & sleep_view[gi]); // RL7 RL10
    end
endgenerate

always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        reg_rdata <= 8'h00;
    end
    else
    begin
        reg_rdata <= rdata_nxt;
    end
end

// ----------------------------------------
// boot wait state machine
// ----------------------------------------
always @*
begin
    boot_state_nxt = boot_state_r;
    case (boot_state_r)
        BOOT_HW:
        begin
            if (!download_busy)
            begin
                boot_state_nxt = BOOT_IDLE; // RL4
            end
        end
        BOOT_IDLE:
        begin
            if (soft_wait)
            begin
                boot_state_nxt = BOOT_SOFT; // RL3
            end
        end
        BOOT_SOFT:
        begin
            if (!soft_wait)
            begin
                boot_state_nxt = BOOT_IDLE; // RL3
            end
        end
        default:
        begin
            boot_state_nxt = BOOT_IDLE;
        end
    endcase
end

always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        boot_state_r    <= BOOT_HW; // RL4
        boot_wait_n_out <= 1'b0;
        boot_wait_oe    <= 1'b1;
    end
    else
    begin
        boot_state_r    <= boot_state_nxt;
        // pin is pulled low only while a wait is due, else released high
        boot_wait_n_out <= (boot_state_nxt == BOOT_IDLE);
        boot_wait_oe    <= (boot_state_nxt != BOOT_IDLE); // RL3 RL4
    end
end

// ----------------------------------------
// upper data pull-ups
// ----------------------------------------
always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        upper_data_pullup_en <= 1'b0;
    end
    else
    begin
        upper_data_pullup_en <= ~out_ctrl_r[`OPDC_OUT_PULLUP_OFF] & ~width_strap_in; // RL5 RL11
    end
end

// ----------------------------------------
// output buffer enable
// ----------------------------------------
always @*
begin
    oe_cnt_nxt = oe_cnt_r;
    if (!oe_req)
    begin
        oe_cnt_nxt = 4'h0;
    end
    else if (oe_cnt_r != 4'hF)
    begin
        oe_cnt_nxt = oe_cnt_r + 4'h1;
    end
end

always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        data_out_en <= 1'b0;
        oe_cnt_r    <= 4'h0;
    end
    else
    begin
        oe_cnt_r <= oe_cnt_nxt;
        if (!oe_req)
        begin
            data_out_en <= 1'b0;
        end
        else if (out_ctrl_r[`OPDC_OUT_TURBO_BIT])
        begin
            data_out_en <= 1'b1; // RL6
        end
        else
        begin
            data_out_en <= slow_oe_done; // RL6
        end
    end
end

// ----------------------------------------
// deep sleep state machine
// ----------------------------------------
always @*
begin
    sleep_state_nxt = sleep_state_r;
    case (sleep_state_r)
        SLP_AWAKE:
        begin
            if (level_wants_sleep(sleep_mode_r, deep_sleep_pin) && sleep_capable)
            begin
                sleep_state_nxt = SLP_ASLEEP; // RL8
            end
        end
        SLP_ASLEEP:
        begin
            if (!mode_listed(sleep_mode_r))
            begin
                sleep_state_nxt = SLP_AWAKE; // RL8 RL12
            end
            else if (is_level_mode(sleep_mode_r))
            begin
                if (!(level_wants_sleep(sleep_mode_r, deep_sleep_pin) && sleep_capable))
                begin
                    sleep_state_nxt = SLP_AWAKE; // RL8
                end
            end
            else if (edge_ends_sleep(sleep_mode_r, deep_sleep_pin, pin_d_r))
            begin
                sleep_state_nxt = SLP_AWAKE; // RL9
            end
        end
        default:
        begin
            sleep_state_nxt = SLP_AWAKE;
        end
    endcase
end

always @(posedge sys_clk or negedge resetn)
begin
    if (!resetn)
    begin
        pin_d_r           <= 1'b0;
        sleep_state_r     <= SLP_AWAKE;
        deep_sleep_active <= 1'b0;
    end
    else
    begin
        pin_d_r           <= deep_sleep_pin;
        sleep_state_r     <= sleep_state_nxt;
        deep_sleep_active <= (sleep_state_nxt == SLP_ASLEEP);
    end
end

endmodule
`default_nettype wire

// file: verification/opdc_host.sv
/* bus master model for the control bank. assumes a slave that samples on sys_clk rise. */
`default_nettype none
module opdc_host (
    input  wire logic        sys_clk,
    output var  logic [12:0] reg_addr,
    output var  logic [7:0]  reg_wdata,
    output var  logic        reg_wr,
    output var  logic        reg_rd,
    input  wire logic [7:0]  reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        @(posedge sys_clk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [12:0] a, output logic [7:0] v);
        @(posedge sys_clk) {reg_addr, reg_rd} <= {a, 1'b1};
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
endmodule
`default_nettype wire

// file: verification/opdc_ctrl_asserts.sv
/* port checker for the control bank. assumes bind to opdc_ctrl. */
`default_nettype none
`include "opdc_defs.vh"
module opdc_ctrl_asserts (
    input wire logic        sys_clk, resetn, reg_wr, reg_rd, soft_reset_mode, download_busy,
    input wire logic        soft_download, sleep_capable, width_strap_in, deep_sleep_pin,
    input wire logic        oe_n_in, ce_n_in, boot_wait_n_out, boot_wait_oe,
    input wire logic        upper_data_pullup_en, data_out_en, deep_sleep_active,
    input wire logic [12:0] reg_addr,
    input wire logic [7:0]  reg_wdata, reg_rdata,
    input wire logic [1:0]  cascade_position_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] oc;
    logic [3:0] md;
    always @(posedge sys_clk or negedge resetn)
        if (!resetn) oc <= 3'h1;
        else if (reg_wr && reg_addr == `OPDC_OFF_OUT_CTRL) oc <= reg_wdata[2:0];
    always @(posedge sys_clk or negedge resetn)
        if (!resetn) md <= 4'h0;
        else if (reg_wr && reg_addr == `OPDC_OFF_SLEEP_CTRL) md <= reg_wdata[3:0];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence quiet;
        $stable(oc) && $stable(md) && $stable(width_strap_in) && $stable(deep_sleep_pin)
            && $stable(sleep_capable);
    endsequence
    sequence sel;
        !oe_n_in && !ce_n_in && $past(oe_n_in || ce_n_in);
    endsequence
    a_out_read:
    assert property (reg_rd && reg_addr == `OPDC_OFF_OUT_CTRL |=> reg_rdata == {5'h00, $past(oc)})
        else $error("output control readback wrong");
    a_sleep_read:
    assert property (reg_rd && reg_addr == `OPDC_OFF_SLEEP_CTRL |=>
        reg_rdata == {$past(sleep_capable), 3'h0, $past(md)}) else $error("sleep readback wrong");
    a_pullup_rule:
    assert property (quiet [*3] |-> upper_data_pullup_en == (!oc[1] && !width_strap_in))
        else $error("pull-up enable wrong");
    a_turbo_fast:
    assert property (oc[2] ##0 sel |=> data_out_en) else $error("turbo enable late");
    a_slow_hold:
    assert property (!oc[2] ##0 sel |=> !data_out_en) else $error("slow enable early");
    a_level_high:
    assert property (md == 4'h4 ##0 quiet [*3] |->
        deep_sleep_active == (deep_sleep_pin && sleep_capable)) else $error("level sleep wrong");
    a_pin_unused:
    assert property ((md != 4'h1 && md != 4'h2 && md != 4'h4 && md != 4'h8) ##0 quiet [*3]
        |-> !deep_sleep_active) else $error("unused pin slept");
    a_wait_soft:
    assert property ((download_busy && soft_download && oc[0]) [*2] |-> boot_wait_oe)
        else $error("boot wait not driven");
    a_exit_rise:
    assert property (md == 4'h1 && deep_sleep_pin && !$past(deep_sleep_pin)
        |=> !deep_sleep_active) else $error("rising edge did not end sleep");
endmodule
bind opdc_ctrl opdc_ctrl_asserts chk (.*);
`default_nettype wire

// file: verification/opdc_ctrl_bench.sv
/* self-checking bench for the control bank. assumes opdc_host drives the register port. */
`default_nettype none
`include "opdc_defs.vh"
module opdc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, resetn = 0, soft_reset_mode = 0, download_busy = 1, soft_download = 0;
    logic sleep_capable = 1, width_strap_in = 0, deep_sleep_pin = 0, oe_n_in = 1, ce_n_in = 1;
    logic [1:0] cascade_position_in = 2'h3;
    logic [12:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic reg_wr, reg_rd, boot_wait_n_out, boot_wait_oe;
    logic upper_data_pullup_en, data_out_en, deep_sleep_active;
    logic [3:0] codes [7] = '{4'h4, 4'h8, 4'h0, 4'h1, 4'h2, 4'h3, 4'hF};
    int fail_count = 0, tests_run = 0, cyc = 0;
    initial forever #10 sys_clk = ~sys_clk;
    opdc_host host (.*);
    opdc_ctrl dut (.*);
    task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task tk(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task final_report;
        if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) if (++cyc > 4000)
    begin
        fail_count++;
        final_report;
    end
    initial
    begin
        tk(2);
        resetn <= 1;
        host.rd(`OPDC_OFF_OUT_CTRL, d); chk("out", d, 8'h01);
        host.rd(`OPDC_OFF_SLEEP_CTRL, d); chk("slp", d, 8'h80);
        chk("woe", boot_wait_oe, 1'b1);
        chk("wn", boot_wait_n_out, 1'b0);
        download_busy <= 0; tk(3); chk("woe", boot_wait_oe, 1'b0);
        chk("wn", boot_wait_n_out, 1'b1);
        soft_reset_mode <= 1; host.wr(`OPDC_OFF_OUT_CTRL, 8'hFA);
        host.rd(`OPDC_OFF_OUT_CTRL, d); chk("out", d, 8'h02);
        chk("pu", upper_data_pullup_en, 1'b0);
        download_busy <= 1; soft_download <= 1; tk(3); chk("woe", boot_wait_oe, 1'b0);
        host.wr(`OPDC_OFF_OUT_CTRL, 8'h01); tk(3); chk("woe", boot_wait_oe, 1'b1);
        chk("wn", boot_wait_n_out, 1'b0);
        chk("pu", upper_data_pullup_en, 1'b1);
        width_strap_in <= 1; tk(3); chk("pu", upper_data_pullup_en, 1'b0);
        download_busy <= 0; soft_download <= 0;
        for (int t = 0; t < 2; t++)
        begin
            host.wr(`OPDC_OFF_OUT_CTRL, t ? 8'h05 : 8'h01);
            {oe_n_in, ce_n_in} <= 2'h0; tk(1); chk("den", data_out_en, t);
            tk(6); chk("den", data_out_en, 1'b1);
            {oe_n_in, ce_n_in} <= 2'h3; tk(2);
        end
        for (int i = 0; i < 7; i++) for (int k = 0; k < 2; k++)
        begin
            host.wr(`OPDC_OFF_SLEEP_CTRL, {4'hF, codes[i]});
            host.rd(`OPDC_OFF_SLEEP_CTRL, d); chk("slp", d, {4'h8, codes[i]});
            deep_sleep_pin <= (k == 0) ^ (codes[i] == 4'h8); tk(4);
            chk("ds", deep_sleep_active, (codes[i] == 4'h4 || codes[i] == 4'h8) && !k);
        end
        for (int e = 0; e < 2; e++)
        begin
            host.wr(`OPDC_OFF_SLEEP_CTRL, e ? 8'h08 : 8'h04);
            deep_sleep_pin <= !e; tk(3); chk("ds", deep_sleep_active, 1'b1);
            host.wr(`OPDC_OFF_SLEEP_CTRL, e ? 8'h02 : 8'h01);
            deep_sleep_pin <= e; tk(3); chk("ds", deep_sleep_active, 1'b1);
            deep_sleep_pin <= !e; tk(3); chk("ds", deep_sleep_active, 1'b0);
        end
        sleep_capable <= 0; host.rd(`OPDC_OFF_SLEEP_CTRL, d); chk("slp", d, 8'h02);
        host.wr(13'h1016, 8'hFF); host.rd(13'h1016, d); chk("gap", d, 8'h00);
        host.rd(`OPDC_OFF_OUT_CTRL, d); chk("out", d, 8'h05);
        final_report;
    end
endmodule
`default_nettype wire
